// ---- hw/asd_baud_tick.sv ----
// Purpose: Bit-period counter that pulses once per programmed baud interval.
// Assumes: period_i is at least 2 and stable during a character.
// Notes:   A restart loads load_i so the first tick can fall mid-bit.
`timescale 1ns/1ps
module asd_baud_tick
   import asd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        restart_i,
   input  wire logic [15:0] load_i,
   input  wire logic [15:0] period_i,
   output logic             tick_o
);

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;

   always_comb begin
      tick_o = 1'b0;
      cnt_d  = cnt_q;
      if (restart_i) begin
         cnt_d = load_i;
      end else if (cnt_q == 16'h0000) begin
         tick_o = 1'b1;
         cnt_d  = period_i - 16'h0001;
      end else begin
         cnt_d = cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= ASD_CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   a_tick_spacing : assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (tick_o && !restart_i && period_i > 16'h0001) |=> !tick_o)
      else $error("baud tick repeated within one period");

endmodule

// ---- hw/asd_data_path.sv ----
// Purpose: Holding registers, transmitter, receiver and line signals of the serial adapter.
// Assumes: Configuration comes from cfg_i and is stable while characters move.
// Notes:   No parity is generated or checked; receive waits one stop-bit time and does not check its level.
`timescale 1ns/1ps
module asd_data_path
   import asd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        bus_sel_i,
   input  wire logic [15:0] bus_addr_i,
   input  wire logic        bus_rw_i,
   input  wire logic [7:0]  bus_wdata_i,
   output logic      [7:0]  bus_rdata_o,
   input  wire asd_cfg_t    cfg_i,
   input  wire logic        td_i,
   output logic             td_o,
   output logic             td_oe_o,
   input  wire logic        rd_i,
   output logic             rd_o,
   output logic             rd_oe_o,
   input  wire logic        cts_n_i,
   input  wire logic        dcd_n_i,
   output logic             rts_n_o,
   output logic             rts_change_o,
   output logic             thr_empty_o,
   output logic             rdr_full_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and control lines.
   logic [3:0] sync1_q, sync2_q;
   logic       dcd_prev_q, rts_n_q, rts_n_d, rts_chg_q, rts_chg_d;
   logic       td_s, rd_s, cts_s, dcd_s;
   assign td_s  = sync2_q[0];
   assign rd_s  = sync2_q[1];
   assign cts_s = sync2_q[2];
   assign dcd_s = sync2_q[3];

   always_comb begin
      rts_n_d   = !cfg_i.rts_on;
      rts_chg_d = cfg_i.data_set && (dcd_s != dcd_prev_q);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q    <= 4'hf;
         sync2_q    <= 4'hf;
         dcd_prev_q <= ASD_MARK;
         rts_n_q    <= ASD_MARK;
         rts_chg_q  <= 1'b0;
      end else begin
         sync1_q    <= {dcd_n_i, cts_n_i, rd_i, td_i};
         sync2_q    <= sync1_q;
         dcd_prev_q <= dcd_s;
         rts_n_q    <= rts_n_d;
         rts_chg_q  <= rts_chg_d;
      end
   end

   assign rts_n_o      = rts_n_q;
   assign rts_change_o = rts_chg_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic       win_hit, wr_stb, rd_stb;
   logic [2:0] last_bit;
   assign win_hit  = bus_sel_i && bus_addr_i >= ASD_WIN_BASE && bus_addr_i <= ASD_WIN_LAST;
   assign wr_stb   = win_hit && !bus_rw_i;
   assign rd_stb   = win_hit && bus_rw_i;
   assign last_bit = ASD_LAST_BIT_BASE + {1'b0, cfg_i.char_len};

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Transmitter.
   asd_tx_state_t tx_st_q, tx_st_d;
   logic [7:0]    thr_q, thr_d, tsr_q, tsr_d;
   logic          thr_empty_q, thr_empty_d;
   logic [2:0]    tx_bit_q, tx_bit_d;
   logic          tx_stop_q, tx_stop_d, tx_line_q, tx_line_d;
   logic          tx_load, tx_tick;
   // A load never shares a cycle with a write, so fresh data is never mistaken for sent.
   assign tx_load = (tx_st_q == TX_IDLE) && !thr_empty_q && (cts_s == ASD_SPACE)
                    && !wr_stb;

   asd_baud_tick u_tx_tick (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .restart_i(tx_load),
      .load_i(cfg_i.baud_div - 16'h0001), .period_i(cfg_i.baud_div), .tick_o(tx_tick));

   always_comb begin
      tx_st_d     = tx_st_q;
      thr_d       = thr_q;
      thr_empty_d = thr_empty_q;
      tsr_d       = tsr_q;
      tx_bit_d    = tx_bit_q;
      tx_stop_d   = tx_stop_q;
      tx_line_d   = tx_line_q;
      if (wr_stb) begin
         thr_d       = bus_wdata_i;
         thr_empty_d = 1'b0;
      end
      case (tx_st_q)
         TX_IDLE: begin
            tx_line_d = ASD_MARK;
            if (tx_load) begin
               tsr_d       = thr_q;
               thr_empty_d = 1'b1;
               tx_line_d   = ASD_SPACE;
               tx_st_d     = TX_START;
            end
         end
         TX_START: begin
            if (tx_tick) begin
               tx_line_d = tsr_q[0];
               tsr_d     = {1'b0, tsr_q[7:1]};
               tx_bit_d  = 3'h0;
               tx_st_d   = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_tick) begin
               if (tx_bit_q == last_bit) begin
                  tx_line_d = ASD_MARK;
                  tx_stop_d = 1'b0;
                  tx_st_d   = TX_STOP;
               end else begin
                  tx_line_d = tsr_q[0];
                  tsr_d     = {1'b0, tsr_q[7:1]};
                  tx_bit_d  = tx_bit_q + 3'h1;
               end
            end
         end
         TX_STOP: begin
            if (tx_tick) begin
               if (cfg_i.two_stop && !tx_stop_q) begin
                  tx_stop_d = 1'b1;
               end else begin
                  tx_st_d = TX_IDLE;
               end
            end
         end
         default: begin
            tx_st_d   = TX_IDLE;
            tx_line_d = ASD_MARK;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_st_q     <= TX_IDLE;
         thr_q       <= ASD_THR_RESET;
         thr_empty_q <= 1'b1;
         tsr_q       <= ASD_THR_RESET;
         tx_bit_q    <= 3'h0;
         tx_stop_q   <= 1'b0;
         tx_line_q   <= ASD_MARK;
      end else begin
         tx_st_q     <= tx_st_d;
         thr_q       <= thr_d;
         thr_empty_q <= thr_empty_d;
         tsr_q       <= tsr_d;
         tx_bit_q    <= tx_bit_d;
         tx_stop_q   <= tx_stop_d;
         tx_line_q   <= tx_line_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Receiver.
   asd_rx_state_t rx_st_q, rx_st_d;
   logic [7:0]    rsr_q, rsr_d, rdr_q, rdr_d;
   logic          rdr_full_q, rdr_full_d;
   logic [2:0]    rx_bit_q, rx_bit_d;
   logic          rx_line, rx_begin, rx_done, rx_tick;
   assign rx_line  = cfg_i.data_set ? td_s : rd_s;
   assign rx_begin = (rx_st_q == RX_IDLE) && (rx_line == ASD_SPACE);

   // The first tick after a start edge falls mid-bit; later ones one period apart.
   asd_baud_tick u_rx_tick (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .restart_i(rx_begin),
      .load_i({1'b0, cfg_i.baud_div[15:1]}), .period_i(cfg_i.baud_div), .tick_o(rx_tick));

   always_comb begin
      rx_st_d  = rx_st_q;
      rsr_d    = rsr_q;
      rx_bit_d = rx_bit_q;
      rx_done  = 1'b0;
      case (rx_st_q)
         RX_IDLE: begin
            rx_st_d = rx_begin ? RX_START : RX_IDLE;
         end
         RX_START: begin
            if (rx_tick) begin
               rsr_d    = ASD_RDR_RESET;
               rx_bit_d = 3'h0;
               rx_st_d  = (rx_line == ASD_SPACE) ? RX_DATA : RX_IDLE;
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               rsr_d[rx_bit_q] = rx_line;
               if (rx_bit_q == last_bit) begin
                  rx_st_d = RX_STOP;
               end else begin
                  rx_bit_d = rx_bit_q + 3'h1;
               end
            end
         end
         RX_STOP: begin
            if (rx_tick) begin
               rx_done = 1'b1;
               rx_st_d = RX_IDLE;
            end
         end
         default: begin
            rx_st_d = RX_IDLE;
         end
      endcase
      rdr_d      = rx_done ? rsr_q : rdr_q;
      rdr_full_d = rx_done ? 1'b1 : (rd_stb ? 1'b0 : rdr_full_q);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_st_q    <= RX_IDLE;
         rsr_q      <= ASD_RDR_RESET;
         rdr_q      <= ASD_RDR_RESET;
         rdr_full_q <= 1'b0;
         rx_bit_q   <= 3'h0;
      end else begin
         rx_st_q    <= rx_st_d;
         rsr_q      <= rsr_d;
         rdr_q      <= rdr_d;
         rdr_full_q <= rdr_full_d;
         rx_bit_q   <= rx_bit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign td_o        = cfg_i.data_set ? ASD_MARK : tx_line_q;
   assign td_oe_o     = !cfg_i.data_set;
   assign rd_o        = cfg_i.data_set ? tx_line_q : ASD_MARK;
   assign rd_oe_o     = cfg_i.data_set;
   assign bus_rdata_o = rdr_q;
   assign thr_empty_o = thr_empty_q;
   assign rdr_full_o  = rdr_full_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_load;
      tx_load;
   endsequence
   sequence s_start_bit;
      (tx_line_q == ASD_SPACE) && (tx_st_q == TX_START);
   endsequence

   a_idle_mark : assert property ((tx_st_q == TX_IDLE) |-> tx_line_q == ASD_MARK)
      else $error("line not at mark while idle");
   a_load_start : assert property (s_load |=> s_start_bit)
      else $error("start bit missing after load");
   a_cts_gate : assert property (s_load |-> $past(cts_n_i, 2) == ASD_SPACE)
      else $error("character started while clear-to-send at mark");
   a_empty_set : assert property (s_load |=> thr_empty_q && tsr_q == $past(thr_q))
      else $error("holding register move not flagged");
   a_empty_clear : assert property (wr_stb |=> !thr_empty_q && thr_q == $past(bus_wdata_i))
      else $error("write did not clear empty flag");
   a_full_set : assert property (rx_done |=> rdr_full_q && rdr_q == $past(rsr_q))
      else $error("received character not flagged");
   a_full_clear : assert property (rd_stb && !rx_done |=> !rdr_full_q)
      else $error("read did not clear full flag");
   a_high_zero : assert property (rx_done |=> (rdr_q >> ({1'b0, last_bit} + 4'h1)) == 8'h00)
      else $error("unused receive bits not zero");
   a_rts_level : assert property ($changed(cfg_i.rts_on) |=> rts_n_o == !$past(cfg_i.rts_on))
      else $error("request-to-send does not follow software");
   a_rts_change : assert property (cfg_i.data_set && $changed(dcd_s) |=> rts_change_o)
      else $error("incoming request change gave no interrupt");
   a_dir_swap : assert property (td_oe_o != rd_oe_o && rd_oe_o == cfg_i.data_set)
      else $error("data line direction wrong");
   a_first_lsb : assert property (s_start_bit ##0 tx_tick |=>
      tx_line_q == $past(tsr_q[0]))
      else $error("first data bit not bit zero");

endmodule

// ---- hw/asd_pkg.sv ----
// Purpose: Shared constants and types of the asynchronous serial data path.
// Assumes: Mark is a logic high on every serial and control pin.
// Notes:   Offsets, reset values and state codes are named only here.
package asd_pkg;

   // Address window that selects both holding registers.
   localparam logic [15:0] ASD_WIN_BASE   = 16'hff00;
   localparam logic [15:0] ASD_WIN_LAST   = 16'hff03;

   // Reset values.
   localparam logic [7:0]  ASD_THR_RESET  = 8'h00;
   localparam logic [7:0]  ASD_RDR_RESET  = 8'h00;
   localparam logic [15:0] ASD_CNT_RESET  = 16'h0000;

   // Character length code 0..3 selects 5..8 data bits; this is the last index for code 0.
   localparam logic [2:0]  ASD_LAST_BIT_BASE = 3'h4;

   // Line levels.
   localparam logic        ASD_MARK       = 1'b1;
   localparam logic        ASD_SPACE      = 1'b0;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'h1,
      TX_START = 4'h2,
      TX_DATA  = 4'h4,
      TX_STOP  = 4'h8
   } asd_tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'h1,
      RX_START = 4'h2,
      RX_DATA  = 4'h4,
      RX_STOP  = 4'h8
   } asd_rx_state_t;

   // Software-held configuration of the data path.
   typedef struct packed {
      logic [15:0] baud_div;   // System clocks per bit, at least 2.
      logic [1:0]  char_len;   // 0..3 means 5..8 data bits.
      logic        two_stop;   // Send two stop bits when set.
      logic        rts_on;     // Drive request-to-send to space when set.
      logic        data_set;   // Data-set operation swaps the data lines.
   } asd_cfg_t;

endpackage

// ---- tb/asd_data_path_tb.sv ----
// Purpose: Self-checking bench of the serial data path against a remote terminal.
// Assumes: Bit period of 8 system clocks, 12 in data-set mode; inputs change at the falling edge.
// Notes:   Each shared pin resolves from the device enable and the remote drive.
`timescale 1ns/1ps
module asd_data_path_tb
   import asd_pkg::*;
;
   logic        sys_clk_i;
   logic        reset_n_i;
   logic        bus_sel_i;
   logic [15:0] bus_addr_i;
   logic        bus_rw_i;
   logic [7:0]  bus_wdata_i;
   logic [7:0]  bus_rdata_o;
   asd_cfg_t    cfg_i;
   logic        td_o, td_oe_o, rd_o, rd_oe_o, td_line, rd_line, p_line, cts_n, dcd_n;
   logic        rts_n_o, rts_change_o, thr_empty_o, rdr_full_o;
   int          num_errors;
   int          comparisons;

   assign td_line = td_oe_o ? td_o : p_line;
   assign rd_line = rd_oe_o ? rd_o : p_line;

   asd_data_path dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus_sel_i(bus_sel_i),
      .bus_addr_i(bus_addr_i), .bus_rw_i(bus_rw_i), .bus_wdata_i(bus_wdata_i),
      .bus_rdata_o(bus_rdata_o), .cfg_i(cfg_i), .td_i(td_line), .td_o(td_o),
      .td_oe_o(td_oe_o), .rd_i(rd_line), .rd_o(rd_o), .rd_oe_o(rd_oe_o), .cts_n_i(cts_n),
      .dcd_n_i(dcd_n), .rts_n_o(rts_n_o), .rts_change_o(rts_change_o),
      .thr_empty_o(thr_empty_o), .rdr_full_o(rdr_full_o));

   asd_remote p (.sys_clk_i(sys_clk_i), .bit_len_i(cfg_i.baud_div),
      .line_i(cfg_i.data_set ? rd_line : td_line), .line_o(p_line), .cts_n_o(cts_n),
      .dcd_n_o(dcd_n));

   initial sys_clk_i = 1'b0;
   always #4 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic access(input logic rw, input logic [15:0] addr, input logic [7:0] wd,
                         output logic [7:0] rd);
      @(negedge sys_clk_i);
      bus_sel_i   = 1'b1;
      bus_rw_i    = rw;
      bus_addr_i  = addr;
      bus_wdata_i = wd;
      @(posedge sys_clk_i);
      rd = bus_rdata_o;
      @(negedge sys_clk_i);
      bus_sel_i = 1'b0;
   endtask

   task automatic wait_flag(input logic want_full);
      int n;
      n = 0;
      while ((want_full ? rdr_full_o : thr_empty_o) !== 1'b1 && n < 400) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= 400) begin
         num_errors++;
         end_sim();
      end
   endtask

   // Counts request-change pulses and spaces on the transmit line over a span.
   task automatic watch(input int cycles, output int pulses, output int spaces);
      pulses = 0;
      spaces = 0;
      repeat (cycles) begin
         @(negedge sys_clk_i);
         pulses += (rts_change_o === 1'b1);
         spaces += (td_line !== ASD_MARK);
      end
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      num_errors++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] r, got, mask;
      logic       ok;
      int         pu, sp;
      num_errors  = 0;
      comparisons = 0;
      reset_n_i   = 1'b0;
      bus_sel_i   = 1'b0;
      bus_rw_i    = 1'b1;
      bus_addr_i  = 16'h0000;
      bus_wdata_i = 8'h00;
      cfg_i       = '{16'h0008, 2'h3, 1'b0, 1'b0, 1'b0};
      repeat (8) @(negedge sys_clk_i);
      check("reset line", {td_o, rts_n_o, thr_empty_o, rdr_full_o}, 16'h000e);
      check("reset rdata", bus_rdata_o, ASD_RDR_RESET);
      reset_n_i = 1'b1;
      cfg_i.rts_on = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      check("rts on", rts_n_o, ASD_SPACE);
      cfg_i.rts_on = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      check("rts off", rts_n_o, ASD_MARK);
      check("terminal oe", {td_oe_o, rd_oe_o}, 16'h0002);
      p.ctl(ASD_SPACE, ASD_MARK);
      access(1'b0, 16'hfeff, 8'h55, r);
      access(1'b0, 16'hff04, 8'h55, r);
      watch(40, pu, sp);
      check("outside write", {thr_empty_o, 8'(sp)}, 16'h0100);
      for (int l = 0; l < 4; l++) begin
         cfg_i.char_len = 2'(l);
         mask = 8'(8'hff >> (3 - l));
         fork
            p.recv(l + 5, 1, got, ok);
            begin
               access(1'b0, 16'hff00 + 16'(l), 8'he5, r);
               check("empty after write", thr_empty_o, 1'b0);
            end
         join
         check("tx char", {ok, got}, {8'h01, 8'he5 & mask});
         check("empty after load", thr_empty_o, 1'b1);
      end
      fork
         p.recv(8, 1, got, ok);
         begin
            access(1'b0, 16'hff02, 8'ha6, r);
            wait_flag(1'b0);
            access(1'b0, 16'hff01, 8'h3c, r);
            repeat (24) @(negedge sys_clk_i);
            p.ctl(ASD_MARK, ASD_MARK);
         end
      join
      check("finish under cts mark", {ok, got}, 16'h01a6);
      watch(120, pu, sp);
      check("cts hold off", {thr_empty_o, 8'(sp)}, 16'h0000);
      fork
         p.recv(8, 1, got, ok);
         p.ctl(ASD_SPACE, ASD_MARK);
      join
      check("resume", {ok, got}, 16'h013c);
      for (int l = 0; l < 4; l++) begin
         cfg_i.char_len = 2'(l);
         mask = 8'(8'hff >> (3 - l));
         p.send(8'hc9 ^ 8'(l), l + 5);
         wait_flag(1'b1);
         access(1'b1, 16'hff04, 8'h00, r);
         check("full kept", rdr_full_o, 1'b1);
         access(1'b1, 16'hff03 - 16'(l), 8'h00, r);
         check("rx char", r, (8'hc9 ^ 8'(l)) & mask);
         check("full cleared", rdr_full_o, 1'b0);
      end
      cfg_i.data_set = 1'b1;
      cfg_i.two_stop = 1'b1;
      cfg_i.baud_div = 16'h000c;
      repeat (2) @(negedge sys_clk_i);
      check("set oe", {td_oe_o, rd_oe_o}, 16'h0001);
      p.send(8'h96, 8);
      wait_flag(1'b1);
      access(1'b1, 16'hff00, 8'h00, r);
      check("set rx", r, 8'h96);
      fork
         p.recv(8, 2, got, ok);
         access(1'b0, 16'hff00, 8'h4b, r);
      join
      check("set tx", {ok, got}, 16'h014b);
      p.ctl(ASD_SPACE, ASD_SPACE);
      watch(12, pu, sp);
      check("request change", pu, 1);
      p.ctl(ASD_SPACE, ASD_MARK);
      watch(12, pu, sp);
      check("request change back", pu, 1);
      cfg_i.data_set = 1'b0;
      p.ctl(ASD_SPACE, ASD_SPACE);
      watch(12, pu, sp);
      check("terminal no change", pu, 0);
      end_sim();
   end
endmodule

// ---- tb/asd_remote.sv ----
// Purpose: Remote terminal that frames, sends and samples serial characters.
// Assumes: Mark is a logic high and a bit lasts bit_len_i system clocks.
// Notes:   The remote party drives both flow-control lines and never releases its line.
`timescale 1ns/1ps
module asd_remote
   import asd_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] bit_len_i,
   input  wire logic        line_i,
   output logic             line_o,
   output logic             cts_n_o,
   output logic             dcd_n_o
);
   initial begin
      line_o  = ASD_MARK;
      cts_n_o = ASD_MARK;
      dcd_n_o = ASD_MARK;
   end

   // Clear-to-send at space lets the device transmit, mark holds it off.
   task automatic ctl(input logic cts_n, input logic dcd_n);
      @(negedge sys_clk_i);
      cts_n_o = cts_n;
      dcd_n_o = dcd_n;
   endtask

   task automatic send(input logic [7:0] data, input int nbits);
      @(negedge sys_clk_i);
      line_o = ASD_SPACE;
      repeat (bit_len_i) @(negedge sys_clk_i);
      for (int i = 0; i < nbits; i++) begin
         line_o = data[i];
         repeat (bit_len_i) @(negedge sys_clk_i);
      end
      line_o = ASD_MARK;
      repeat (bit_len_i) @(negedge sys_clk_i);
   endtask

   // Samples each bit in its middle, so a wrong bit period corrupts the value.
   task automatic recv(input int nbits, input int nstop, output logic [7:0] data,
                       output logic ok);
      int n;
      data = 8'h00;
      ok   = 1'b0;
      n    = 0;
      while (line_i !== ASD_SPACE && n < 4000) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= 4000) return;
      repeat (bit_len_i / 2) @(negedge sys_clk_i);
      if (line_i !== ASD_SPACE) return;
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_len_i) @(negedge sys_clk_i);
         data[i] = line_i;
      end
      for (int i = 0; i < nstop; i++) begin
         repeat (bit_len_i) @(negedge sys_clk_i);
         if (line_i !== ASD_MARK) return;
      end
      ok = 1'b1;
   endtask
endmodule
